// ==== rtl/dps_pkg.sv ====
// Purpose: Constants and types for the dual PLL power-up sequencer
// Assumes: 125 MHz system clock, 10 MHz sequencing tick
// Notes: All sequencing counts are in 10 MHz oscillator cycles
package dps_pkg;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_MHZ = 125;
   localparam int OSC_MHZ = 10;
   localparam int CNT_W = 22;
   localparam int DIV_W = 8;
   localparam int CAL_MIN_US = 30;
   localparam int CAL_MAX_MS = 300;
   localparam int CAL_DEF_US = 300;
   localparam int VCO_MIN_US = 20;
   localparam int VCO_MAX_MS = 200;
   localparam int VCO_DEF_US = 400;
   localparam logic [CNT_W-1:0] CAL_MIN = CNT_W'(CAL_MIN_US * OSC_MHZ);
   localparam logic [CNT_W-1:0] CAL_MAX =
      CNT_W'(CAL_MAX_MS * 1000 * OSC_MHZ);
   localparam logic [CNT_W-1:0] CAL_DEF = CNT_W'(CAL_DEF_US * OSC_MHZ);
   localparam logic [CNT_W-1:0] VCO_MIN = CNT_W'(VCO_MIN_US * OSC_MHZ);
   localparam logic [CNT_W-1:0] VCO_MAX =
      CNT_W'(VCO_MAX_MS * 1000 * OSC_MHZ);
   localparam logic [CNT_W-1:0] VCO_DEF = CNT_W'(VCO_DEF_US * OSC_MHZ);
   localparam logic [DIV_W-1:0] DIV_STEP = DIV_W'(OSC_MHZ);
   localparam logic [DIV_W-1:0] DIV_MOD = DIV_W'(CLK_MHZ);
   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [4:0] A_CTRL = 5'h00;
   localparam logic [4:0] A_CAL1 = 5'h04;
   localparam logic [4:0] A_VCO1 = 5'h08;
   localparam logic [4:0] A_CAL2 = 5'h0c;
   localparam logic [4:0] A_VCO2 = 5'h10;
   localparam logic [4:0] A_STAT = 5'h14;
   localparam logic [4:0] A_IRQS = 5'h18;
   localparam logic [4:0] A_IRQM = 5'h1c;
   localparam int B_ORDER = 0;
   localparam int B_SRST = 7;
   localparam int B_RT0 = 8;
   localparam int B_RT1 = 10;
   localparam logic [1:0] RT_LOL1 = 2'h1;
   localparam logic [1:0] RT_LOL2 = 2'h2;
   localparam logic [1:0] RT0_DEF = RT_LOL1;
   localparam logic [1:0] RT1_DEF = RT_LOL2;
   localparam int S_XO = 0;
   localparam int S_EN1 = 1;
   localparam int S_EN2 = 2;
   localparam int S_LOL1 = 3;
   localparam int S_LOL2 = 4;
   localparam int S_ST1 = 8;
   localparam int S_ST2 = 12;
   localparam int IRQ_W = 4;
   localparam int I_EN1 = 0;
   localparam int I_EN2 = 1;
   localparam int I_LK1 = 2;
   localparam int I_LK2 = 3;
   localparam logic [2:0] SZ_WORD = 3'h2;
   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      PS_IDLE, PS_CAL, PS_VCO, PS_LOCK, PS_DONE
   } dps_pll_state_e;
   typedef struct packed {
      logic [CNT_W-1:0] cal;
      logic [CNT_W-1:0] vco;
   } dps_pll_cfg_s;
   typedef struct packed {
      dps_pll_state_e state;
      logic out_en;
      logic loss_of_lock_flag;
   } dps_pll_stat_s;
endpackage

// ==== rtl/dps_pll_seq.sv ====
// Purpose: Calibration, VCO wait and lock tracking for one PLL
// Assumes: tick is a one-cycle 10 MHz enable
// Notes: clear restarts the PLL from idle
`timescale 1ns/1ps
`default_nettype none
module dps_pll_seq
   import dps_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Sequencing control
   input wire logic clear,
   input wire logic tick,
   input wire logic start,
   input wire dps_pll_cfg_s cfg,
   // Loop feedback
   input wire logic locked,
   input wire logic pfd_tick,
   // Status
   output var dps_pll_stat_s stat
);
   typedef struct packed {
      dps_pll_state_e st;
      logic [CNT_W-1:0] cnt;
      logic en;
      logic loss_of_lock_flag;
      logic seen;
   } dps_seq_s;
   localparam dps_seq_s SEQ_RST =
      '{st: PS_IDLE, cnt: '0, en: 1'b0, loss_of_lock_flag: 1'b1, seen: 1'b0};
   dps_seq_s r;
   dps_seq_s next_r;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // ************************************************************
   // Sequence
   // ************************************************************
   always_comb begin
      next_r = r;
      if (clear) begin
         next_r = SEQ_RST;
      end else begin
         unique case (r.st)
            PS_IDLE: begin
               if (start) begin
                  next_r.st = PS_CAL;
                  next_r.cnt = cfg.cal;
               end
            end
            PS_CAL: begin
               if (tick) begin
                  if (r.cnt <= CNT_W'(1)) begin
                     next_r.st = PS_VCO;
                     next_r.cnt = cfg.vco;
                  end else begin
                     next_r.cnt = r.cnt - CNT_W'(1);
                  end
               end
            end
            PS_VCO: begin
               if (tick) begin
                  if (r.cnt <= CNT_W'(1)) begin
                     next_r.st = PS_LOCK;
                     next_r.en = 1'b1;
                  end else begin
                     next_r.cnt = r.cnt - CNT_W'(1);
                  end
               end
            end
            PS_LOCK: begin
               // Lock must hold for two consecutive clocks, the second on a phase-detector tick
               next_r.seen = locked;
               if (r.seen && locked && pfd_tick) begin
                  next_r.loss_of_lock_flag = 1'b0;
                  next_r.st = PS_DONE;
               end
            end
            PS_DONE: begin
               if (!locked) begin
                  next_r.loss_of_lock_flag = 1'b1;
                  next_r.seen = 1'b0;
                  next_r.st = PS_LOCK;
               end
            end
            default: begin
               next_r = SEQ_RST;
            end
         endcase
      end
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         r <= SEQ_RST;
      end else begin
         r <= next_r;
      end
   end
   assign stat = '{state: r.st, out_en: r.en, loss_of_lock_flag: r.loss_of_lock_flag};
   // ************************************************************
   // Checks
   // ************************************************************
   cal_load_a: assert property (
      (r.st == PS_IDLE && start && !clear)
      |=> (r.st == PS_CAL && r.cnt == $past(cfg.cal)))
      else $error("calibration count not loaded on start");
   out_enable_a: assert property (
      (r.st == PS_VCO && tick && r.cnt <= CNT_W'(1) && !clear)
      |=> (r.en && r.st == PS_LOCK))
      else $error("outputs not enabled after VCO wait");
   lol_high_a: assert property (
      (r.st != PS_DONE) |-> r.loss_of_lock_flag)
      else $error("loss of lock low before lock");
   lol_fall_a: assert property (
      $fell(r.loss_of_lock_flag) |-> ($past(pfd_tick) && $past(r.seen)))
      else $error("loss of lock fell without a locked PFD cycle");
endmodule
`default_nettype wire

// ==== rtl/dps_sequencer.sv ====
// Purpose: Power-up sequencer for a dual PLL clock generator
// Assumes: 125 MHz clock, pins synchronous, AHB-Lite register bus
// Notes: Sequencing counts advance on a 10 MHz tick from a divider
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Hold reset until core and bank supplies good
// - Stall PLL start until crystal amplitude good
// - Run PLL1 calibration count, 30us to 300ms
// - Then run VCO1 wait count, 20us to 200ms
// - Enable PLL outputs right after VCO wait
// - Loss of lock drops at the first PFD tick after lock has held a clock
// - Run PLL2 calibration count, 30us to 300ms
// - Then run VCO2 wait count, 20us to 200ms
// - Order bit: PLL2 after PLL1, or parallel
// - Power-down low disables device and host port
// - Power-down rise reloads order bit from strap, other registers to defaults
// - After reset release, counters then calibration run
// - Soft reset bit repeats whole power-on reset
module dps_sequencer
   import dps_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Power and configuration pins
   input wire logic power_down_n,
   input wire logic core_supply_ok,
   input wire logic first_output_bank_supply,
   input wire logic cfg_parallel_strap,
   // Crystal
   input wire logic xtal_used,
   input wire logic xtal_amp_ok,
   // PLL feedback
   input wire logic pll1_locked,
   input wire logic pll2_locked,
   input wire logic pfd1_tick,
   input wire logic pfd2_tick,
   // Clock path enables and pins
   output logic pll1_out_en,
   output logic pll2_out_en,
   output logic status_pin_zero,
   output logic status_pin_one,
   output logic host_if_en,
   output logic irq,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp
);
   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic pdn_s1;
      logic pdn_s2;
      logic sup_s1;
      logic sup_s2;
      logic por;
      logic xo_ok;
      logic tick;
      logic [DIV_W-1:0] acc;
      logic order;
      logic [1:0] rt0;
      logic [1:0] rt1;
      dps_pll_cfg_s c1;
      dps_pll_cfg_s c2;
      logic [IRQ_W-1:0] ist;
      logic [IRQ_W-1:0] imask;
      logic [1:0] en_q;
      logic [1:0] lol_q;
      logic a_wr;
      logic a_map;
      logic [2:0] a_idx;
      logic [31:0] rdata;
      logic s0;
      logic s1;
   } dps_top_s;
   localparam dps_top_s TOP_RST = '{
      por: 1'b1,
      rt0: RT0_DEF,
      rt1: RT1_DEF,
      c1: '{cal: CAL_DEF, vco: VCO_DEF},
      c2: '{cal: CAL_DEF, vco: VCO_DEF},
      lol_q: 2'h3,
      default: '0
   };
   dps_top_s r;
   dps_top_s next_r;
   dps_pll_stat_s st1;
   dps_pll_stat_s st2;
   logic start2;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [CNT_W-1:0] clamp(
      input logic [CNT_W-1:0] v,
      input logic [CNT_W-1:0] lo,
      input logic [CNT_W-1:0] hi
   );
      clamp = (v < lo) ? lo : (v > hi) ? hi : v;
   endfunction
   function automatic logic route(
      input logic [1:0] sel,
      input logic l1,
      input logic l2
   );
      route = (sel == RT_LOL1) ? l1 : (sel == RT_LOL2) ? l2 : 1'b0;
   endfunction
   // ************************************************************
   // Per-PLL sequencers
   // ************************************************************
   // Serial order waits for PLL1 lock to keep the VCOs apart
   assign start2 = r.xo_ok && (r.order || st1.state == PS_DONE);
   dps_pll_seq u_pll1 (
      .clock(clock),
      .arst_n(arst_n),
      .clear(r.por),
      .tick(r.tick),
      .start(r.xo_ok),
      .cfg(r.c1),
      .locked(pll1_locked),
      .pfd_tick(pfd1_tick),
      .stat(st1)
   );
   dps_pll_seq u_pll2 (
      .clock(clock),
      .arst_n(arst_n),
      .clear(r.por),
      .tick(r.tick),
      .start(start2),
      .cfg(r.c2),
      .locked(pll2_locked),
      .pfd_tick(pfd2_tick),
      .stat(st2)
   );
   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic [DIV_W-1:0] sum;
      logic [IRQ_W-1:0] ev;
      logic [IRQ_W-1:0] w1c;
      logic [31:0] rd;
      logic acc_a;
      sum = '0;
      ev = '0;
      w1c = '0;
      rd = '0;
      acc_a = 1'b0;
      next_r = r;
      // Two-flop synchronisers on the pin and supply monitors
      next_r.pdn_s1 = power_down_n;
      next_r.pdn_s2 = r.pdn_s1;
      next_r.sup_s1 = core_supply_ok & first_output_bank_supply;
      next_r.sup_s2 = r.sup_s1;
      // Fractional divider: 125 MHz to a 10 MHz tick
      sum = r.acc + DIV_STEP;
      next_r.tick = (sum >= DIV_MOD);
      next_r.acc = next_r.tick ? sum - DIV_MOD : sum;
      // Power-on reset
      next_r.por = !(r.pdn_s2 && r.sup_s2);
      // Crystal amplitude gate, sampled on the oscillator tick
      if (r.tick && !r.xo_ok) begin
         next_r.xo_ok = !xtal_used || xtal_amp_ok;
      end
      // Events
      ev[I_EN1] = st1.out_en & ~r.en_q[0];
      ev[I_EN2] = st2.out_en & ~r.en_q[1];
      ev[I_LK1] = r.lol_q[0] & ~st1.loss_of_lock_flag;
      ev[I_LK2] = r.lol_q[1] & ~st2.loss_of_lock_flag;
      next_r.en_q = {st2.out_en, st1.out_en};
      next_r.lol_q = {st2.loss_of_lock_flag, st1.loss_of_lock_flag};
      // Status pins
      next_r.s0 = route(r.rt0, st1.loss_of_lock_flag, st2.loss_of_lock_flag);
      next_r.s1 = route(r.rt1, st1.loss_of_lock_flag, st2.loss_of_lock_flag);
      // Bus address phase
      acc_a = hsel && htrans[1] && hready && hsize == SZ_WORD;
      next_r.a_wr = acc_a && hwrite;
      next_r.a_idx = haddr[4:2];
      next_r.a_map = (haddr[31:5] == 27'h0);
      if (acc_a && !hwrite) begin
         unique case (haddr[4:0])
            A_CTRL: begin
               rd[B_ORDER] = r.order;
               rd[B_RT0+:2] = r.rt0;
               rd[B_RT1+:2] = r.rt1;
            end
            A_CAL1: rd[CNT_W-1:0] = r.c1.cal;
            A_VCO1: rd[CNT_W-1:0] = r.c1.vco;
            A_CAL2: rd[CNT_W-1:0] = r.c2.cal;
            A_VCO2: rd[CNT_W-1:0] = r.c2.vco;
            A_STAT: begin
               rd[S_XO] = r.xo_ok;
               rd[S_EN1] = st1.out_en;
               rd[S_EN2] = st2.out_en;
               rd[S_LOL1] = st1.loss_of_lock_flag;
               rd[S_LOL2] = st2.loss_of_lock_flag;
               rd[S_ST1+:3] = st1.state;
               rd[S_ST2+:3] = st2.state;
            end
            A_IRQS: rd[IRQ_W-1:0] = r.ist;
            A_IRQM: rd[IRQ_W-1:0] = r.imask;
            default: rd = '0;
         endcase
         if (!next_r.a_map) begin
            rd = '0;
         end
         next_r.rdata = rd;
      end
      // Bus data phase writes
      if (r.a_wr && r.a_map) begin
         case ({r.a_idx, 2'b00})
            A_CTRL: begin
               next_r.order = hwdata[B_ORDER];
               next_r.rt0 = hwdata[B_RT0+:2];
               next_r.rt1 = hwdata[B_RT1+:2];
               if (hwdata[B_SRST]) begin
                  next_r.por = 1'b1;
               end
            end
            A_CAL1: begin
               next_r.c1.cal = clamp(hwdata[CNT_W-1:0],
                  CAL_MIN, CAL_MAX);
            end
            A_VCO1: begin
               next_r.c1.vco = clamp(hwdata[CNT_W-1:0],
                  VCO_MIN, VCO_MAX);
            end
            A_CAL2: begin
               next_r.c2.cal = clamp(hwdata[CNT_W-1:0],
                  CAL_MIN, CAL_MAX);
            end
            A_VCO2: begin
               next_r.c2.vco = clamp(hwdata[CNT_W-1:0],
                  VCO_MIN, VCO_MAX);
            end
            A_IRQS: w1c = hwdata[IRQ_W-1:0];
            A_IRQM: next_r.imask = hwdata[IRQ_W-1:0];
            default: begin
            end
         endcase
      end
      // A new event beats a clear in the same cycle
      next_r.ist = (r.ist & ~w1c) | ev;
      // Held reset: crystal gate, control, count and interrupt registers back to initial state, order from strap
      if (r.por) begin
         next_r.xo_ok = 1'b0;
         next_r.order = cfg_parallel_strap;
         next_r.rt0 = RT0_DEF;
         next_r.rt1 = RT1_DEF;
         next_r.c1 = TOP_RST.c1;
         next_r.c2 = TOP_RST.c2;
         next_r.ist = '0;
         next_r.imask = '0;
         next_r.a_wr = 1'b0;
      end
   end
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         r <= TOP_RST;
      end else begin
         r <= next_r;
      end
   end
   // ************************************************************
   // Outputs
   // ************************************************************
   assign pll1_out_en = st1.out_en;
   assign pll2_out_en = st2.out_en;
   assign status_pin_zero = r.s0;
   assign status_pin_one = r.s1;
   // Host port is off for the whole reset; reads then see defaults
   assign host_if_en = !r.por;
   assign irq = |(r.ist & r.imask);
   assign hreadyout = 1'b1;
   assign hrdata = r.rdata;
   assign hresp = 1'b0;
   // ************************************************************
   // Checks
   // ************************************************************
   supply_hold_a: assert property (
      !r.sup_s2 |=> (r.por ##1 (!pll1_out_en && !pll2_out_en)))
      else $error("reset released with a supply low");
   xo_stall_a: assert property (
      !r.xo_ok |-> (st1.state == PS_IDLE && st2.state == PS_IDLE))
      else $error("PLL started before crystal ready");
   serial_order_a: assert property (
      (st2.state == PS_IDLE && !r.order && st1.state != PS_DONE)
      |=> st2.state == PS_IDLE)
      else $error("PLL2 started before PLL1 lock");
   parallel_order_a: assert property (
      (r.xo_ok && r.order && st2.state == PS_IDLE && !r.por)
      |=> st2.state == PS_CAL)
      else $error("PLL2 did not start in parallel");
   pin_down_a: assert property (
      !power_down_n |-> ##3 !host_if_en ##1 (!pll1_out_en && !pll2_out_en))
      else $error("device active while power-down low");
   strap_load_a: assert property (
      (r.por && !next_r.por) |=> (r.order == $past(cfg_parallel_strap)
      && r.c1.cal == CAL_DEF && r.c2.vco == VCO_DEF))
      else $error("initial state not loaded at reset release");
   soft_reset_a: assert property (
      (r.a_wr && r.a_map && r.a_idx == A_CTRL[4:2] && hwdata[B_SRST])
      |=> (r.por ##1 (st1.state == PS_IDLE && !pll2_out_en)))
      else $error("soft reset did not restart the device");
   tick_rate_a: assert property (
      r.tick |=> !r.tick [*8])
      else $error("oscillator tick faster than 10 MHz");
endmodule
`default_nettype wire

// ==== tb/dps_far_model.sv ====
// Purpose: Far-side model: host pin driver and PLL analog feedback
// Assumes: Shares the 125 MHz clock with the sequencer
// Notes: Lock comes 40 clocks after the outputs turn on
`timescale 1ns/1ps
`default_nettype none
module dps_far_model
   import dps_pkg::*;
(
   // Clock
   input wire logic clock,
   // Commands from the bench
   input wire logic pd_req,
   input wire logic xo_go,
   // Enables seen from the device
   input wire logic pll1_out_en,
   input wire logic pll2_out_en,
   // Pins and feedback to the device
   output logic power_down_n,
   output logic xtal_amp_ok,
   output logic pll1_locked,
   output logic pll2_locked,
   output logic pfd1_tick,
   output logic pfd2_tick
);
   logic pd_q = 1'b0;
   logic xo_q = 1'b0;
   logic [2:0] pfd_cnt = 3'h0;
   logic [5:0] lk1 = 6'h0;
   logic [5:0] lk2 = 6'h0;
   // Loop settles only after the outputs are already on, as in silicon
   always_ff @(posedge clock) begin
      pd_q <= pd_req;
      xo_q <= xo_go;
      pfd_cnt <= pfd_cnt + 3'h1;
      lk1 <= pll1_out_en ? lk1 + {5'h0, lk1 != 6'h28} : 6'h0;
      lk2 <= pll2_out_en ? lk2 + {5'h0, lk2 != 6'h28} : 6'h0;
   end
   assign power_down_n = !pd_q;
   assign xtal_amp_ok = xo_q;
   assign pll1_locked = lk1 == 6'h28;
   assign pll2_locked = lk2 == 6'h28;
   assign pfd1_tick = pfd_cnt == 3'h0;
   assign pfd2_tick = pfd_cnt == 3'h4;
endmodule
`default_nettype wire

// ==== tb/dps_sequencer_tb.sv ====
// Purpose: Self-checking bench for the dual PLL power-up sequencer
// Assumes: Minimum counts are written while the crystal is not yet good
// Notes: Serial start first, then parallel start after a power-down
`timescale 1ns/1ps
`default_nettype none
module dps_sequencer_tb
   import dps_pkg::*;
;
   typedef struct packed {
      logic [5:0] a;
      logic w;
      logic [31:0] d;
      logic [31:0] e;
   } dps_row_s;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic core_supply_ok = 1'b0;
   logic first_output_bank_supply = 1'b0;
   logic cfg_parallel_strap = 1'b0;
   logic pd_req = 1'b0;
   logic xo_go = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = SZ_WORD;
   logic [31:0] hwdata = 32'h0;
   logic power_down_n, xtal_amp_ok, pll1_locked, pll2_locked;
   logic pfd1_tick, pfd2_tick, pll1_out_en, pll2_out_en;
   logic status_pin_zero, status_pin_one, host_if_en, irq, hreadyout, hresp;
   logic xtal_used = 1'b1;
   logic [31:0] hrdata;
   logic [31:0] q;
   logic [6:0] obs;
   int err_count = 0;
   int checked = 0;
   int n;
   time t0;
   // Defaults, clamping at both ends, read-only and unmapped places
   dps_row_s rows [12] = '{
      '{6'h00, 1'b0, 32'h0, 32'h900}, '{6'h04, 1'b0, 32'h0, 32'hbb8},
      '{6'h08, 1'b0, 32'h0, 32'hfa0}, '{6'h14, 1'b0, 32'h0, 32'h18},
      '{6'h04, 1'b1, 32'h0, 32'h12c}, '{6'h08, 1'b1, 32'h1, 32'hc8},
      '{6'h0c, 1'b1, 32'h3fffff, 32'h2dc6c0},
      '{6'h0c, 1'b1, 32'h12c, 32'h12c}, '{6'h10, 1'b1, 32'h0, 32'hc8},
      '{6'h14, 1'b1, 32'hffff, 32'h18}, '{6'h20, 1'b1, 32'h5, 32'h0},
      '{6'h1c, 1'b1, 32'hf, 32'hf}};
   assign obs = {pll1_locked, irq, status_pin_one, status_pin_zero,
      pll2_out_en, pll1_out_en, host_if_en};
   always #4 clock = ~clock;
   dps_far_model u_far (
      .clock, .pd_req, .xo_go, .pll1_out_en, .pll2_out_en, .power_down_n,
      .xtal_amp_ok, .pll1_locked, .pll2_locked, .pfd1_tick, .pfd2_tick);
   dps_sequencer u_dut (
      .clock, .arst_n, .power_down_n, .core_supply_ok,
      .first_output_bank_supply, .cfg_parallel_strap, .xtal_used,
      .xtal_amp_ok, .pll1_locked, .pll2_locked, .pfd1_tick, .pfd2_tick,
      .pll1_out_en, .pll2_out_en, .status_pin_zero, .status_pin_one,
      .host_if_en, .irq, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp);
   // ********
   // Tasks
   // ********
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chb(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask
   // Samples on the falling edge so flop updates have landed
   task automatic wt(input int k, input logic v, input int lim);
      for (n = 0; n < lim && obs[k] !== v; n++) @(negedge clock);
      if (n == lim) chb(1'b0, 1'b1);
   endtask
   task automatic bus(input logic [31:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] r);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      r = hrdata;
      chb(hresp, 1'b0);
   endtask
   task automatic summarize;
      $display("checked %0d, err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ********
   // Sequence
   // ********
   initial begin
      repeat (60000) @(posedge clock);
      err_count++;
      summarize();
   end
   initial begin
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      core_supply_ok <= 1'b1;
      repeat (20) @(posedge clock);
      chb(host_if_en, 1'b0);
      first_output_bank_supply <= 1'b1;
      wt(0, 1'b1, 10);
      chb(n >= 3 && n <= 4, 1'b1);
      foreach (rows[i]) begin
         if (rows[i].w) bus({26'h0, rows[i].a}, 1'b1, rows[i].d, q);
         bus({26'h0, rows[i].a}, 1'b0, 32'h0, q);
         chk(q, rows[i].e);
      end
      // Serial order keeps the two loops from locking together
      repeat (500) @(posedge clock);
      bus(32'h14, 1'b0, 32'h0, q);
      chk(q, 32'h18);
      xo_go <= 1'b1;
      wt(1, 1'b1, 7000);
      chb(n >= 6245 && n <= 6285, 1'b1);
      chb(pll2_out_en, 1'b0);
      chb(status_pin_zero, 1'b1);
      chb(pll1_locked, 1'b0);
      wt(6, 1'b1, 100);
      wt(3, 1'b0, 20);
      chb(n >= 1 && n <= 11, 1'b1);
      t0 = $time;
      chb(irq, 1'b1);
      bus(32'h1c, 1'b1, 32'h0, q);
      @(negedge clock);
      chb(irq, 1'b0);
      bus(32'h18, 1'b0, 32'h0, q);
      chk(q, 32'h5);
      bus(32'h18, 1'b1, 32'h5, q);
      bus(32'h18, 1'b0, 32'h0, q);
      chk(q, 32'h0);
      bus(32'h1c, 1'b1, 32'hf, q);
      @(negedge clock);
      chb(irq, 1'b0);
      wt(2, 1'b1, 7000);
      n = int'(($time - t0) / 8);
      chb(n >= 6236 && n <= 6255, 1'b1);
      wt(4, 1'b0, 100);
      chb(irq, 1'b1);
      @(posedge clock);
      cfg_parallel_strap <= 1'b1;
      pd_req <= 1'b1;
      xo_go <= 1'b0;
      wt(0, 1'b0, 10);
      chb(n >= 3 && n <= 5, 1'b1);
      // Enables clear one edge after the host port goes off
      @(negedge clock);
      chb(pll1_out_en | pll2_out_en, 1'b0);
      bus(32'h04, 1'b1, 32'h0, q);
      pd_req <= 1'b0;
      wt(0, 1'b1, 10);
      bus(32'h00, 1'b0, 32'h0, q);
      chk(q, 32'h901);
      bus(32'h04, 1'b0, 32'h0, q);
      chk(q, 32'hbb8);
      for (int i = 0; i < 4; i++) bus(32'h4 + 32'(4 * i), 1'b1, 32'h0, q);
      xo_go <= 1'b1;
      wt(1, 1'b1, 7000);
      chb(pll2_out_en, 1'b1);
      bus(32'h00, 1'b1, 32'h981, q);
      wt(1, 1'b0, 10);
      chb(n <= 3, 1'b1);
      wt(3, 1'b1, 10);
      bus(32'h00, 1'b0, 32'h0, q);
      chk(q, 32'h901);
      // No crystal: the amplitude gate is bypassed after a soft reset
      xtal_used <= 1'b0;
      xo_go <= 1'b0;
      bus(32'h00, 1'b1, 32'h80, q);
      repeat (20) @(posedge clock);
      bus(32'h14, 1'b0, 32'h0, q);
      chk(q, 32'h1119);
      summarize();
   end
endmodule
`default_nettype wire
